// ---- logic/alert_mask_map.vh ----
// Address map, reset values and field positions of the alert gating block
`ifndef ALERT_MASK_MAP_VH
`define ALERT_MASK_MAP_VH

// ----------------------------------------------------------------
// Address windows (upper five address bits pick the window)
// ----------------------------------------------------------------
`define FLAG_WINDOW            5'h10
`define MASK_WINDOW            5'h11

// ----------------------------------------------------------------
// Flag registers, read-only, cleared on read
// ----------------------------------------------------------------
`define ADDR_GENERAL_FLAGS     8'h80
`define ADDR_VOLT_TEMP_FLAGS   8'h81
`define ADDR_CUR_POWER_FLAGS   8'h82
`define ADDR_CHARGE_FLAGS      8'h83
`define ADDR_ENERGY_FLAGS      8'h84
`define ADDR_ACCUM_OVF_FLAGS   8'h85
`define ADDR_TIMEBASE_FLAGS    8'h86
`define ADDR_SUPPLY_FLAGS      8'h87

// ----------------------------------------------------------------
// Mask registers, read-write
// ----------------------------------------------------------------
`define ADDR_GENERAL_MASK      8'h88
`define ADDR_VOLT_TEMP_MASK    8'h89
`define ADDR_CUR_POWER_MASK    8'h8a
`define ADDR_CHARGE_MASK       8'h8b
`define ADDR_ENERGY_MASK       8'h8c
`define ADDR_ACCUM_OVF_MASK    8'h8d
`define ADDR_TIMEBASE_MASK     8'h8e
`define ADDR_SUPPLY_MASK       8'h8f

// ----------------------------------------------------------------
// Alert control register
// ----------------------------------------------------------------
`define ADDR_ALERT_CTRL        8'he8
`define MASTER_ENABLE_BIT      0
`define ALERT_CTRL_RESET       1'b0

// ----------------------------------------------------------------
// Mask reset values
// ----------------------------------------------------------------
`define RST_GENERAL_MASK       8'h79
`define RST_VOLT_TEMP_MASK     8'h3f
`define RST_CUR_POWER_MASK     8'h0f
`define RST_CHARGE_MASK        8'h3f
`define RST_ENERGY_MASK        8'h3f
`define RST_ACCUM_OVF_MASK     8'h33
`define RST_TIMEBASE_MASK      8'h33
`define RST_SUPPLY_MASK        8'h03

// ----------------------------------------------------------------
// Flag bits that exist in each flag register
// ----------------------------------------------------------------
`define VALID_GENERAL_FLAGS    8'h79
`define VALID_VOLT_TEMP_FLAGS  8'h3f
`define VALID_CUR_POWER_FLAGS  8'h0f
`define VALID_CHARGE_FLAGS     8'h0f
`define VALID_ENERGY_FLAGS     8'h0f
`define VALID_ACCUM_OVF_FLAGS  8'h33
`define VALID_TIMEBASE_FLAGS   8'h33
`define VALID_SUPPLY_FLAGS     8'h03

`endif

// ---- logic/flag_latch.v ----
// Sticky event flags that clear bit by bit, a new event winning the clear
`timescale 1ns/10ps
module flag_latch #(
  parameter       WIDTH = 8,
  parameter [7:0] VALID = 8'hff
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             rst_n,
  // Events and clears
  input  wire [WIDTH-1:0] set,
  input  wire [WIDTH-1:0] clr,
  // Latched flags
  output wire [WIDTH-1:0] flags
);

  reg  [WIDTH-1:0] flags_reg;
  wire [WIDTH-1:0] flags_next;

  // Set wins over clear so an event in the read cycle is kept
  assign flags_next = ((flags_reg & ~clr) | set) & VALID[WIDTH-1:0];

  // Flags latch regardless of any mask
  always @(posedge mclk) begin
    if (!rst_n) begin
      flags_reg <= {WIDTH{1'b0}};
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule

// ---- logic/mask_reg.v ----
// One read-write alert mask register with its own reset pattern
`timescale 1ns/10ps
module mask_reg #(
  parameter       WIDTH = 8,
  parameter [7:0] RESET = 8'hff
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             rst_n,
  // Write port
  input  wire             wr,
  input  wire [WIDTH-1:0] wdata,
  // Stored mask
  output wire [WIDTH-1:0] mask
);

  reg [WIDTH-1:0] stored_reg;

  // All bits are stored, so undefined bits read back what was last written
  always @(posedge mclk) begin
    if (!rst_n) begin
      stored_reg <= RESET[WIDTH-1:0];
    end else if (wr) begin
      stored_reg <= wdata;
    end
  end

  assign mask = stored_reg;

endmodule

// ---- logic/alert_mask_gating.v ----
// Alert gating: flag registers, mask registers and the alert pin driver
`timescale 1ns/10ps
`include "alert_mask_map.vh"

module alert_mask_gating (
  // Clock and reset
  input  wire       mclk,
  input  wire       rst_n,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output wire [7:0] reg_rdata,
  output wire       reg_rvalid,
  // Flag events, one-cycle pulses per bit
  input  wire [7:0] evt_general,
  input  wire [7:0] evt_volt_temp,
  input  wire [7:0] evt_current_power,
  input  wire [7:0] evt_charge,
  input  wire [7:0] evt_energy,
  input  wire [7:0] evt_accum_overflow,
  input  wire [7:0] evt_timebase,
  input  wire [7:0] evt_supply,
  // Open-drain alert pin
  output wire       alert_out,
  output wire       alert_oe,
  // Groups holding an unmasked flag
  output wire [7:0] alert_cause
);

  // ----------------------------------------------------------------
  // Group tables
  // ----------------------------------------------------------------

  // Group 0 sits lowest; group index equals the low address bits
  localparam [63:0] FLAG_VALID = {
    `VALID_SUPPLY_FLAGS,
    `VALID_TIMEBASE_FLAGS,
    `VALID_ACCUM_OVF_FLAGS,
    `VALID_ENERGY_FLAGS,
    `VALID_CHARGE_FLAGS,
    `VALID_CUR_POWER_FLAGS,
    `VALID_VOLT_TEMP_FLAGS,
    `VALID_GENERAL_FLAGS
  };

  // Mask defaults, every defined gate starts blocked
  localparam [63:0] MASK_RESET = {
    `RST_SUPPLY_MASK,
    `RST_TIMEBASE_MASK,
    `RST_ACCUM_OVF_MASK,
    `RST_ENERGY_MASK,
    `RST_CHARGE_MASK,
    `RST_CUR_POWER_MASK,
    `RST_VOLT_TEMP_MASK,
    `RST_GENERAL_MASK
  };

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------

  wire [63:0] evt_bus;
  wire [63:0] flag_bus;
  wire [63:0] mask_bus;
  wire [63:0] clr_bus;
  wire [63:0] pending_bus;
  wire [7:0]  group_pending;
  wire [7:0]  group_sel;
  wire [7:0]  flag_rd_sel;
  wire [7:0]  mask_wr_sel;
  wire [5:0]  lane_base;
  wire [7:0]  flag_word;
  wire [7:0]  mask_word;
  wire        any_pending;

  reg         in_flag_window;
  reg         in_mask_window;
  reg         ctrl_hit;
  reg  [2:0]  group_idx;
  reg         master_enable_reg;
  reg         master_enable_next;
  reg  [7:0]  rdata_reg;
  reg  [7:0]  rdata_next;
  reg         rvalid_reg;
  reg         alert_oe_reg;
  reg  [7:0]  alert_cause_reg;

  // ----------------------------------------------------------------
  // Event gathering
  // ----------------------------------------------------------------

  // Pack the per-register event ports into one bus
  assign evt_bus = {
    evt_supply,
    evt_timebase,
    evt_accum_overflow,
    evt_energy,
    evt_charge,
    evt_current_power,
    evt_volt_temp,
    evt_general
  };

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // One compare per register; anything off the map hits nothing, so
  // its reads return zero and its writes fall away
  always @* begin
    in_flag_window = 1'b0;
    in_mask_window = 1'b0;
    ctrl_hit       = 1'b0;
    group_idx      = 3'h0;
    if (reg_addr == `ADDR_GENERAL_FLAGS) begin
      in_flag_window = 1'b1;
      group_idx      = 3'h0;
    end else if (reg_addr == `ADDR_VOLT_TEMP_FLAGS) begin
      in_flag_window = 1'b1;
      group_idx      = 3'h1;
    end else if (reg_addr == `ADDR_CUR_POWER_FLAGS) begin
      in_flag_window = 1'b1;
      group_idx      = 3'h2;
    end else if (reg_addr == `ADDR_CHARGE_FLAGS) begin
      in_flag_window = 1'b1;
      group_idx      = 3'h3;
    end else if (reg_addr == `ADDR_ENERGY_FLAGS) begin
      in_flag_window = 1'b1;
      group_idx      = 3'h4;
    end else if (reg_addr == `ADDR_ACCUM_OVF_FLAGS) begin
      in_flag_window = 1'b1;
      group_idx      = 3'h5;
    end else if (reg_addr == `ADDR_TIMEBASE_FLAGS) begin
      in_flag_window = 1'b1;
      group_idx      = 3'h6;
    end else if (reg_addr == `ADDR_SUPPLY_FLAGS) begin
      in_flag_window = 1'b1;
      group_idx      = 3'h7;
    end else if (reg_addr == `ADDR_GENERAL_MASK) begin
      in_mask_window = 1'b1;
      group_idx      = 3'h0;
    end else if (reg_addr == `ADDR_VOLT_TEMP_MASK) begin
      in_mask_window = 1'b1;
      group_idx      = 3'h1;
    end else if (reg_addr == `ADDR_CUR_POWER_MASK) begin
      in_mask_window = 1'b1;
      group_idx      = 3'h2;
    end else if (reg_addr == `ADDR_CHARGE_MASK) begin
      in_mask_window = 1'b1;
      group_idx      = 3'h3;
    end else if (reg_addr == `ADDR_ENERGY_MASK) begin
      in_mask_window = 1'b1;
      group_idx      = 3'h4;
    end else if (reg_addr == `ADDR_ACCUM_OVF_MASK) begin
      in_mask_window = 1'b1;
      group_idx      = 3'h5;
    end else if (reg_addr == `ADDR_TIMEBASE_MASK) begin
      in_mask_window = 1'b1;
      group_idx      = 3'h6;
    end else if (reg_addr == `ADDR_SUPPLY_MASK) begin
      in_mask_window = 1'b1;
      group_idx      = 3'h7;
    end else if (reg_addr == `ADDR_ALERT_CTRL) begin
      ctrl_hit = 1'b1;
    end else begin
      group_idx = 3'h0;
    end
  end

  // One-hot register select within a bank
  assign group_sel = 8'h01 << group_idx;

  // Flag reads clear, mask writes store; flag writes are dropped
  assign flag_rd_sel = (reg_rd && in_flag_window) ? group_sel : 8'h00;
  assign mask_wr_sel = (reg_wr && in_mask_window) ? group_sel : 8'h00;

  // Byte lane of the addressed register inside the packed buses
  assign lane_base = {group_idx, 3'h0};
  assign flag_word = flag_bus[lane_base +: 8];
  assign mask_word = mask_bus[lane_base +: 8];

  // ----------------------------------------------------------------
  // Per-register flags and masks
  // ----------------------------------------------------------------

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : grp
      // Clear exactly the bits the host is reading this cycle
      assign clr_bus[g*8 +: 8] = flag_rd_sel[g] ? flag_bus[g*8 +: 8]
                                                : 8'h00;

      // Flags latch whatever the mask says
      flag_latch #(
        .WIDTH (8),
        .VALID (FLAG_VALID[g*8 +: 8])
      ) u_flags (
        .mclk  (mclk),
        .rst_n (rst_n),
        .set   (evt_bus[g*8 +: 8]),
        .clr   (clr_bus[g*8 +: 8]),
        .flags (flag_bus[g*8 +: 8])
      );

      // Mask register with its own default
      mask_reg #(
        .WIDTH (8),
        .RESET (MASK_RESET[g*8 +: 8])
      ) u_mask (
        .mclk  (mclk),
        .rst_n (rst_n),
        .wr    (mask_wr_sel[g]),
        .wdata (reg_wdata),
        .mask  (mask_bus[g*8 +: 8])
      );

      // A zero mask bit lets its flag through, a one blocks it
      assign pending_bus[g*8 +: 8] = flag_bus[g*8 +: 8]
                                   & ~mask_bus[g*8 +: 8];

      // Per-register summary of unmasked flags
      assign group_pending[g] = |pending_bus[g*8 +: 8];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Gate positions
  // ----------------------------------------------------------------

  // Every mask bit sits on the flag bit it gates, so the AND above
  // needs no remapping; map of the gates by register:
  // 0x88 general
  // bit 4 result_refresh_gate
  // bit 5 converter_fault_gate, resets blocked
  // bit 6 timebase_fault_gate, resets blocked
  // 0x89 volt/temp, bits 0-5 in this order
  //   voltage_high_gate, voltage_low_gate,
  //   temperature_high_gate, temperature_low_gate,
  //   fan_temp_high_gate, fan_temp_low_gate
  // 0x8a current/power, bits 0-3 in this order
  //   current_high_gate, current_low_gate,
  //   power_high_gate, power_low_gate
  // 0x8b charge, bits 0-3; bits 4, 5 only store
  //   charge_one_high/low_gate, charge_two_high/low_gate
  // 0x8c energy, bits 0-3; bits 4, 5 only store
  //   energy_one_high/low_gate, energy_two_high/low_gate
  // 0x8d overflow, bits 0, 1 charge and 4, 5 energy
  //   energy gates follow their flag bits, so the 0x33
  //   default blocks all four overflow flags
  // 0x8e timebase, bits 0, 1 limit and 4, 5 overflow
  // 0x8f supply, bit 0 high and bit 1 low

  // ----------------------------------------------------------------
  // Alert control register
  // ----------------------------------------------------------------

  // Only the master enable bit is kept here
  // Other bits of the control byte are dropped and read as zero
  always @* begin
    master_enable_next = master_enable_reg;
    if (reg_wr && ctrl_hit) begin
      master_enable_next = reg_wdata[`MASTER_ENABLE_BIT];
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      master_enable_reg <= `ALERT_CTRL_RESET;
    end else begin
      master_enable_reg <= master_enable_next;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Unmapped addresses read as zero
  always @* begin
    rdata_next = 8'h00;
    if (in_flag_window) begin
      rdata_next = flag_word;
    end else if (in_mask_window) begin
      rdata_next = mask_word;
    end else if (ctrl_hit) begin
      rdata_next[`MASTER_ENABLE_BIT] = master_enable_reg;
    end else begin
      rdata_next = 8'h00;
    end
  end

  // Data is captured on the read strobe and held until the next read
  always @(posedge mclk) begin
    if (!rst_n) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd;
      if (reg_rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign reg_rdata  = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  // ----------------------------------------------------------------
  // Alert pin
  // ----------------------------------------------------------------

  // Any unmasked flag anywhere asks for the alert
  assign any_pending = |group_pending;

  // Registered so the pin never glitches while flags and masks move;
  // costs one cycle of latency
  always @(posedge mclk) begin
    if (!rst_n) begin
      alert_oe_reg    <= 1'b0;
      alert_cause_reg <= 8'h00;
    end else begin
      alert_oe_reg    <= master_enable_reg & any_pending;
      alert_cause_reg <= group_pending;
    end
  end

  // Open drain: only ever pulls low, release leaves it to the pull-up
  assign alert_out   = 1'b0;
  assign alert_oe    = alert_oe_reg;
  assign alert_cause = alert_cause_reg;

endmodule

// ---- tb/alert_mask_gating_monitor.sv ----
// Port checker for the alert gating block
`timescale 1ns/10ps
module alert_mask_gating_monitor (
  // Clock and reset
  input logic       mclk,
  input logic       rst_n,
  // Register port
  input logic [7:0] reg_addr,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_rdata,
  input logic       reg_rvalid,
  // Events and alert pin
  input logic [7:0] evt_volt_temp,
  input logic       alert_out,
  input logic       alert_oe,
  input logic [7:0] alert_cause
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Alert pin
  // ----------------------------------------------------------------
  property p_out_low;
    alert_out == 1'b0;
  endproperty
  a_out_low: assert property (p_out_low)
    else $error("alert data not low");
  property p_oe_cause;
    alert_oe |-> alert_cause != 8'h00;
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("alert driven with no cause");
  // Enable changes land two edges after the write
  property p_oe_hold;
    alert_oe && !$past(reg_wr) |=> alert_oe || alert_cause == 8'h00;
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("alert released with cause held");
  property p_oe_rise;
    $rose(alert_oe) |-> $rose(alert_cause != 8'h00) ||
      $past(reg_wr && reg_addr == 8'he8, 2);
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("alert rose without cause or enable");

  // ----------------------------------------------------------------
  // Flags and register port
  // ----------------------------------------------------------------
  property p_cause_rise;
    $rose(alert_cause[1]) |-> $past(evt_volt_temp != 8'h00, 2) ||
      $past(reg_wr, 2);
  endproperty
  a_cause_rise: assert property (p_cause_rise)
    else $error("cause rose without event or mask write");
  property p_cause_fall;
    $fell(alert_cause[1]) |-> $past(reg_rd && reg_addr == 8'h81, 2) ||
      $past(reg_wr, 2);
  endproperty
  a_cause_fall: assert property (p_cause_fall)
    else $error("cause fell without read or mask write");
  property p_rvalid;
    reg_rd |=> reg_rvalid;
  endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read not answered");
  property p_no_rvalid;
    !reg_rd |=> !reg_rvalid;
  endproperty
  a_no_rvalid: assert property (p_no_rvalid)
    else $error("answer without read");
  property p_rdata_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without read");
endmodule

bind alert_mask_gating alert_mask_gating_monitor u_mon (
  .mclk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
  .evt_volt_temp, .alert_out, .alert_oe, .alert_cause
);

// ---- tb/host_alert_sense.sv ----
// Host-side model of the open-drain alert line
`timescale 1ns/10ps
module host_alert_sense (
  // Pin driver of the device
  input  logic alert_out,
  input  logic alert_oe,
  // Line level seen by the host
  output logic alert_n
);
  // Pull-up wins whenever the device lets go of the line
  assign alert_n = alert_oe ? alert_out : 1'b1;
endmodule

// ---- tb/tb_alert_mask_gating.sv ----
// Self-checking bench for the alert gating block
`timescale 1ns/10ps
module tb_alert_mask_gating;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] evt [8];
  wire  [7:0] reg_rdata;
  wire        reg_rvalid;
  wire        alert_out;
  wire        alert_oe;
  wire        alert_n;
  wire  [7:0] alert_cause;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  logic [7:0] rst_val [8] = '{8'h79, 8'h3f, 8'h0f, 8'h3f,
                              8'h3f, 8'h33, 8'h33, 8'h03};
  // One existing flag bit per group; 0x10 picks one bit of the energy overflow pair
  logic [7:0] bit_sel [8] = '{8'h20, 8'h20, 8'h08, 8'h08,
                              8'h08, 8'h10, 8'h20, 8'h02};

  alert_mask_gating u_dut (
    .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_rvalid,
    .evt_general(evt[0]), .evt_volt_temp(evt[1]),
    .evt_current_power(evt[2]), .evt_charge(evt[3]),
    .evt_energy(evt[4]), .evt_accum_overflow(evt[5]),
    .evt_timebase(evt[6]), .evt_supply(evt[7]),
    .alert_out, .alert_oe, .alert_cause
  );
  host_alert_sense u_host (.alert_out, .alert_oe, .alert_n);

  // Clock and hang guard
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  // Answer stands for the cycle after the read edge only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk({7'h00, reg_rvalid}, 8'h01);
    d = reg_rdata;
  endtask
  task automatic pulse(input int g, input logic [7:0] b);
    @(negedge mclk);
    evt[g] = b;
    @(negedge mclk);
    evt[g] = 8'h00;
    repeat (2) @(negedge mclk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    for (int i = 0; i < 8; i++) evt[i] = 8'h00;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(8'h88 + i[7:0], d);
      chk(d, rst_val[i]);
      wr(8'h88 + i[7:0], 8'h00);
      rd(8'h88 + i[7:0], d);
      chk(d, 8'h00);
      wr(8'h88 + i[7:0], rst_val[i]);
    end
    rd(8'h90, d);
    chk(d, 8'h00);
    rd(8'he8, d);
    chk(d, 8'h00);
    wr(8'he8, 8'hff);
    rd(8'he8, d);
    chk(d, 8'h01);
    wr(8'h81, 8'hff);
    rd(8'h81, d);
    chk(d, 8'h00);
    $display("test registers done");
    // Masked refresh flag latches but stays off the pin
    wr(8'he8, 8'h01);
    pulse(0, 8'h10);
    chk({7'h00, alert_n}, 8'h01);
    rd(8'h80, d);
    chk(d, 8'h10);
    rd(8'h80, d);
    chk(d, 8'h00);
    // Event in the read cycle outlives the clear
    pulse(1, 8'h01);
    @(negedge mclk);
    reg_addr = 8'h81;
    reg_rd = 1'b1;
    evt[1] = 8'h01;
    @(negedge mclk);
    reg_rd = 1'b0;
    evt[1] = 8'h00;
    chk({7'h00, reg_rvalid}, 8'h01);
    chk(reg_rdata, 8'h01);
    rd(8'h81, d);
    chk(d, 8'h01);
    rd(8'h81, d);
    chk(d, 8'h00);
    $display("test masked flag done");
    for (int g = 0; g < 8; g++) begin
      wr(8'h88 + g[7:0], rst_val[g] & ~bit_sel[g]);
      pulse(g, bit_sel[g]);
      chk({7'h00, alert_n}, 8'h00);
      chk(alert_cause, 8'h01 << g);
      rd(8'h80 + g[7:0], d);
      chk(d, bit_sel[g]);
      @(negedge mclk);
      chk({7'h00, alert_n}, 8'h01);
      wr(8'h88 + g[7:0], rst_val[g]);
    end
    $display("test groups done");
    // Timebase fault held back by the master enable
    wr(8'he8, 8'h00);
    wr(8'h88, 8'h39);
    pulse(0, 8'h40);
    chk({7'h00, alert_n}, 8'h01);
    chk(alert_cause, 8'h01);
    wr(8'he8, 8'h01);
    @(negedge mclk);
    chk({7'h00, alert_n}, 8'h00);
    wr(8'h88, 8'h79);
    @(negedge mclk);
    chk({7'h00, alert_n}, 8'h01);
    rd(8'h80, d);
    chk(d, 8'h40);
    $display("test enable done");
    // Mid-run reset brings masks, flags and enable back to defaults
    wr(8'h8a, 8'h00);
    pulse(2, 8'h01);
    chk({7'h00, alert_n}, 8'h00);
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    chk({7'h00, alert_n}, 8'h01);
    chk(reg_rdata, 8'h00);
    rd(8'h8a, d);
    chk(d, 8'h0f);
    rd(8'h82, d);
    chk(d, 8'h00);
    rd(8'he8, d);
    chk(d, 8'h00);
    $display("test reset done");
    end_of_test();
  end
endmodule
